//--- mdm_map.vh
// Register map, field positions, frame layout and timing of the management master.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef MDM_MAP_VH
`define MDM_MAP_VH

// Command register location
`define MDM_ADDR_W 20
`define MDM_CMD_OFFSET 20'h0_0020

// Command register fields
`define MDM_DATA_MSB 15
`define MDM_DATA_LSB 0
`define MDM_REG_MSB 20
`define MDM_REG_LSB 16
`define MDM_DEV_MSB 25
`define MDM_DEV_LSB 21
`define MDM_KIND_MSB 27
`define MDM_KIND_LSB 26
`define MDM_READY_BIT 28
`define MDM_IE_BIT 29
`define MDM_ERR_BIT 30

// Field reset values
`define MDM_DATA_RST 16'h0000
`define MDM_IDX_RST 5'h00
`define MDM_KIND_RST 2'h0
`define MDM_READY_RST 1'h1
`define MDM_IE_RST 1'h0
`define MDM_ERR_RST 1'h0
`define MDM_DATA_ERR 16'hFFFF

// Command kinds
`define MDM_KIND_WRITE 2'h1
`define MDM_KIND_READ 2'h2

// Frame pieces
`define MDM_PREAMBLE 32'hFFFF_FFFF
`define MDM_START 2'h1
`define MDM_RD_CODE 2'h2
`define MDM_WR_TURN 2'h2
`define MDM_RD_PAD 18'h0_0000
`define MDM_WR_PAD 2'h0

// Bit positions within a frame
`define MDM_WR_BITS 7'h3E
`define MDM_RD_OUT_BITS 7'h2E
`define MDM_RD_TA2_BIT 7'h2F
`define MDM_RD_DATA_BIT 7'h30
`define MDM_RD_BITS 7'h40
`define MDM_CNT_ONE 7'h01
`define MDM_CNT_ZERO 7'h00

// Timing: system clock rate and management clock ceiling, in kHz
`define MDM_SYS_CLK_KHZ 40000
`define MDM_MDC_MAX_KHZ 2500
`define MDM_HALF_CYCLES ((`MDM_SYS_CLK_KHZ + 2 * `MDM_MDC_MAX_KHZ - 1) / (2 * `MDM_MDC_MAX_KHZ))
`define MDM_DONE_LIMIT_US 64

`endif

//--- mdm_mdc_gen.v
// Management clock divider: makes the link clock from the system clock.
// Assumes run is held for the whole frame; clock rests low while run is low.
`timescale 1ns/10ps
module mdm_mdc_gen #(
    parameter HALF = 8
) (
    input wire sys_clk,
    input wire rstn,
    input wire run,
    output reg mdc,
    output wire rise_tick,
    output wire fall_tick
);
    localparam [7:0] CNT_ZERO = 8'h00;
    localparam [7:0] CNT_ONE = 8'h01;
    localparam [7:0] HALF_LAST = HALF[7:0] - CNT_ONE;

    reg [7:0] cnt_r;
    wire at_last;

    assign at_last = run && (cnt_r == HALF_LAST);
    // Pulses in the cycle before the clock edge they announce
    assign rise_tick = at_last && !mdc;
    assign fall_tick = at_last && mdc;

    // Half-period counter and clock toggle
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= CNT_ZERO;
            mdc <= 1'b0;
        end else if (!run) begin
            cnt_r <= CNT_ZERO;
            mdc <= 1'b0;
        end else if (at_last) begin
            cnt_r <= CNT_ZERO;
            mdc <= !mdc;
        end else begin
            cnt_r <= cnt_r + CNT_ONE;
        end
    end
endmodule

//--- mdm_master.v
// Management master: one command register drives a serial frame to the PHY.
// Assumes a single-cycle register write port on sys_clk and an external MDIO wire.
//
// How it works
// - Write shifts the 16-bit data field out; read stores received bits there.
// - Register index sits in command bits 20:16, selecting PHY register 0 to 31.
// - Kind bits 27:26: 01 means write, 10 means read, others reserved.
// - A reserved kind starts no frame on the link.
// - Ready bit 28 sets when a transaction completes; resets to one.
// - With enable bit 29 set, completion raises an interrupt.
// - Error bit 30 sets when a read fails to complete.
// - Read drives preamble, 01, 10, device, register, then releases the line.
// - Read drops the leading returned bit and keeps the following sixteen.
// - Write drives preamble, 01, device, register, 10, data, then idle.
// - Completion pulses the interrupt if enabled, then sets ready.
// - Write sets ready only after the whole frame has gone out.
// - Command to ready takes no longer than 64 microseconds.
// - Nonzero second turnaround bit aborts: error set, data all ones, ready set.
`timescale 1ns/10ps
`include "mdm_map.vh"
module mdm_master #(
    parameter HALF_CYCLES = `MDM_HALF_CYCLES
) (
    input wire sys_clk,
    input wire rstn,
    input wire [`MDM_ADDR_W-1:0] reg_addr,
    input wire reg_wr,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata,
    output reg irq_done,
    output wire mdc,
    input wire mdio_in,
    output reg mdio_out,
    output reg mdio_oe
);
    // Controller states
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_SHIFT = 2'h1;
    localparam [1:0] ST_FIN = 2'h2;

    // Worst frame: 64 bits of two half periods, held below the completion limit
    localparam integer FRAME_CYCLES = 64 * 2 * HALF_CYCLES + 2;
    localparam integer LIMIT_CYCLES = `MDM_DONE_LIMIT_US * (`MDM_SYS_CLK_KHZ / 1000);

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [15:0] data_r;
    reg [4:0] reg_idx_r;
    reg [4:0] dev_idx_r;
    reg [1:0] kind_r;
    reg ready_r;
    reg ie_r;
    reg err_r;
    reg [63:0] sr_r;
    reg [6:0] bit_cnt_r;
    reg mdio_meta_r;
    reg mdio_sync_r;
    wire cmd_sel;
    wire cmd_wr;
    wire kind_ok;
    wire is_read;
    wire rise_tick;
    wire fall_tick;
    wire [6:0] frame_last;
    wire [6:0] bit_next;
    wire [4:0] wr_reg;
    wire [4:0] wr_dev;
    wire [1:0] wr_kind;
    wire [15:0] wr_data;
    wire [31:0] cmd_view;
    wire ta_fail;

    assign cmd_sel = (reg_addr == `MDM_CMD_OFFSET);
    // Commands only land while idle
    assign cmd_wr = reg_wr && cmd_sel && (state_r == ST_IDLE);
    assign wr_data = reg_wdata[`MDM_DATA_MSB:`MDM_DATA_LSB];
    assign wr_reg = reg_wdata[`MDM_REG_MSB:`MDM_REG_LSB];
    assign wr_dev = reg_wdata[`MDM_DEV_MSB:`MDM_DEV_LSB];
    assign wr_kind = reg_wdata[`MDM_KIND_MSB:`MDM_KIND_LSB];
    assign kind_ok = (wr_kind == `MDM_KIND_WRITE) || (wr_kind == `MDM_KIND_READ);
    assign is_read = (kind_r == `MDM_KIND_READ);
    assign frame_last = (is_read ? `MDM_RD_BITS : `MDM_WR_BITS) - `MDM_CNT_ONE;
    assign bit_next = bit_cnt_r + `MDM_CNT_ONE;
    // Second turnaround bit must come back low
    assign ta_fail = is_read && rise_tick && (bit_cnt_r == `MDM_RD_TA2_BIT) && mdio_sync_r;

    // Register view; bit 31 reads as zero
    assign cmd_view = {1'b0, err_r, ie_r, ready_r, kind_r, dev_idx_r, reg_idx_r, data_r};

    // Link clock divider, at most 2.5 MHz
    mdm_mdc_gen #(
        .HALF(HALF_CYCLES)
    ) u_mdc_gen (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .run(state_r == ST_SHIFT),
        .mdc(mdc),
        .rise_tick(rise_tick),
        .fall_tick(fall_tick)
    );

    // Two-flop synchroniser for the returned data line
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mdio_meta_r <= 1'b0;
            mdio_sync_r <= 1'b0;
        end else begin
            mdio_meta_r <= mdio_in;
            mdio_sync_r <= mdio_meta_r;
        end
    end

    // Next controller state
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (cmd_wr && kind_ok) begin
                    state_nxt = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (ta_fail || (fall_tick && bit_cnt_r == frame_last)) begin
                    state_nxt = ST_FIN;
                end
            end
            ST_FIN: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // State register
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Command fields, ready and error flags
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            data_r <= `MDM_DATA_RST;
            reg_idx_r <= `MDM_IDX_RST;
            dev_idx_r <= `MDM_IDX_RST;
            kind_r <= `MDM_KIND_RST;
            ready_r <= `MDM_READY_RST;
            ie_r <= `MDM_IE_RST;
            err_r <= `MDM_ERR_RST;
        end else if (cmd_wr) begin
            data_r <= wr_data;
            reg_idx_r <= wr_reg;
            dev_idx_r <= wr_dev;
            kind_r <= wr_kind;
            ie_r <= reg_wdata[`MDM_IE_BIT];
            err_r <= reg_wdata[`MDM_ERR_BIT];
            // Reserved kind: nothing on the link, ready comes straight back
            ready_r <= kind_ok ? reg_wdata[`MDM_READY_BIT] : `MDM_READY_RST;
        end else if (ta_fail) begin
            err_r <= 1'b1;
            data_r <= `MDM_DATA_ERR;
        end else if (state_r == ST_SHIFT && is_read && rise_tick && bit_cnt_r >= `MDM_RD_DATA_BIT) begin
            // Leading bit skipped; sixteen data bits shifted in MSB first
            data_r <= {data_r[14:0], mdio_sync_r};
        end else if (state_r == ST_FIN) begin
            // Ready follows the interrupt pulse by one cycle
            ready_r <= 1'b1;
        end
    end

    // Completion interrupt pulse, one cycle, when enabled
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_done <= 1'b0;
        end else begin
            irq_done <= (state_r == ST_SHIFT) && (state_nxt == ST_FIN) && ie_r;
        end
    end

    // Frame shifter and bit counter
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sr_r <= 64'h0000_0000_0000_0000;
            bit_cnt_r <= `MDM_CNT_ZERO;
        end else if (cmd_wr && kind_ok) begin
            bit_cnt_r <= `MDM_CNT_ZERO;
            if (wr_kind == `MDM_KIND_READ) begin
                sr_r <= {`MDM_PREAMBLE, `MDM_START, `MDM_RD_CODE, wr_dev, wr_reg, `MDM_RD_PAD};
            end else begin
                // Write frame is 62 bits; left-aligned so the preamble leads from the top bit
                sr_r <= {`MDM_PREAMBLE, `MDM_START, wr_dev, wr_reg, `MDM_WR_TURN, wr_data, `MDM_WR_PAD};
            end
        end else if (state_r == ST_SHIFT && fall_tick) begin
            sr_r <= {sr_r[62:0], 1'b0};
            bit_cnt_r <= bit_next;
        end
    end

    // Line drive: launched at frame start and on each falling link clock
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0;
        end else if (cmd_wr && kind_ok) begin
            mdio_out <= 1'b1;
            mdio_oe <= 1'b1;
        end else if (state_r != ST_SHIFT || state_nxt != ST_SHIFT) begin
            // Released when idle and once the frame ends
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0;
        end else if (fall_tick) begin
            mdio_out <= sr_r[62];
            // Read releases the line after the register index
            mdio_oe <= !is_read || (bit_next < `MDM_RD_OUT_BITS);
        end
    end

    // Registered read data; unmapped addresses read zero
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= cmd_sel ? cmd_view : 32'h0000_0000;
        end
    end
endmodule

//--- mdm_master_monitor.sv
// Port checks for the management master.
// Assumes reg_addr rests on the command register while frames run.
`timescale 1ns/10ps
`include "mdm_map.vh"
module mdm_master_monitor #(
    parameter HALF_CYCLES = 8
) (
    input wire sys_clk,
    input wire rstn,
    input wire [`MDM_ADDR_W-1:0] reg_addr,
    input wire reg_wr,
    input wire [31:0] reg_wdata,
    input wire [31:0] reg_rdata,
    input wire irq_done,
    input wire mdc,
    input wire mdio_in,
    input wire mdio_out,
    input wire mdio_oe
);
    reg [7:0] run_r;
    reg mdc_q_r;
    wire sel = reg_addr == `MDM_CMD_OFFSET;
    wire take = reg_wr && sel && reg_rdata[28];
    wire go = take && (reg_wdata[27:26] == 2'h1 || reg_wdata[27:26] == 2'h2);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Cycles the link clock has held its level
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mdc_q_r <= 1'b0;
            run_r <= 8'h00;
        end else begin
            mdc_q_r <= mdc;
            run_r <= (mdc != mdc_q_r) ? 8'h01 : run_r + {7'h00, run_r != 8'hFF};
        end
    end
    // Frame start, then ready cleared; completion, then ready set
    sequence start_s;
        mdio_oe && mdio_out ##1 !reg_rdata[28];
    endsequence
    sequence done_s;
        !reg_rdata[28] ##1 reg_rdata[28];
    endsequence
    frame_start_a: assert property (go |=> start_s) else $error("no frame start");
    field_store_a: assert property (take |-> ##2 reg_rdata[27:16] == $past(reg_wdata[27:16], 2))
        else $error("fields not stored");
    reserved_quiet_a: assert property (take && !go |=> (!mdio_oe && !mdc) [*8])
        else $error("link used on reserved kind");
    idle_release_a: assert property ($past(sel) && !$past(reg_wr) && reg_rdata[28] |-> !mdio_oe && !mdc)
        else $error("line driven when idle");
    done_order_a: assert property (irq_done && sel |-> !mdio_oe ##1 done_s)
        else $error("bad completion order");
    irq_enable_a: assert property (irq_done && $past(sel) |-> reg_rdata[29]) else $error("irq not enabled");
    clock_rate_a: assert property ($rose(mdc) |-> run_r >= HALF_CYCLES) else $error("link clock fast");
    out_stable_a: assert property ($changed(mdio_out) && mdio_oe && $past(mdio_oe) |-> $fell(mdc))
        else $error("data moved with clock high");
endmodule
bind mdm_master mdm_master_monitor #(.HALF_CYCLES(HALF_CYCLES)) u_mdm_master_monitor (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .irq_done(irq_done), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe)
);

//--- mdm_phy_model.sv
// Behavioural PHY management port.
// Assumes a pull-up on the data line; records every bit seen on the wire.
`timescale 1ns/10ps
module mdm_phy_model (
    input wire mdc,
    input wire mdio_out,
    input wire mdio_oe,
    input wire bad_ta,
    input wire [15:0] rd_data,
    output wire mdio_in,
    output reg [63:0] got
);
    integer cnt = 0;
    reg rd = 1'b0;
    reg drv_oe = 1'b0;
    reg drv_v = 1'b0;
    // Wire level: master, then PHY, else the pull-up
    assign mdio_in = mdio_oe ? mdio_out : (drv_oe ? drv_v : 1'b1);
    // New frame when the master takes the line
    always @(posedge mdio_oe) begin
        cnt = 0;
    end
    // Sample each bit at the rise, set up the next answer bit
    always @(posedge mdc) begin
        got = {got[62:0], mdio_in};
        if (cnt == 35) begin
            rd = got[3:0] == 4'h6;
        end
        drv_oe <= rd && cnt >= 46 && cnt <= 62;
        drv_v <= (cnt == 46) ? bad_ta : rd_data[62 - cnt];
        cnt = cnt + 1;
    end
endmodule

//--- mdio_management_master_tb_top.sv
// Bench for the management master against the PHY model.
// Assumes a 200 ns link clock from HALF_CYCLES of 4.
`timescale 1ns/10ps
`include "mdm_map.vh"
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin fail_count++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module mdio_management_master_tb_top;
    reg sys_clk = 1'b0;
    reg rstn = 1'b0;
    reg [19:0] reg_addr = `MDM_CMD_OFFSET;
    reg reg_wr = 1'b0;
    reg [31:0] reg_wdata = 32'h0000_0000;
    reg bad_ta = 1'b0;
    reg [15:0] rd_data = 16'h0000;
    wire [31:0] reg_rdata;
    wire irq_done, mdc, mdio_in, mdio_out, mdio_oe;
    wire [63:0] got;
    integer fail_count = 0, checks = 0, cyc = 0, irqs = 0, edges = 0, n;
    mdm_master #(.HALF_CYCLES(4)) u_mdm_master (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_done(irq_done), .mdc(mdc),
        .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe));
    mdm_phy_model u_mdm_phy_model (.mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .bad_ta(bad_ta),
        .rd_data(rd_data), .mdio_in(mdio_in), .got(got));
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge mdc) edges = edges + 1;
    // Interrupt count and hang guard
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        irqs = irqs + (irq_done === 1'b1);
        if (cyc == 6000) begin
            fail_count++;
            end_of_test;
        end
    end
    task end_of_test;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task wr(input [19:0] a, input [31:0] d);
        @(posedge sys_clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = `MDM_CMD_OFFSET;
    endtask
    // Command with ready and error cleared, then wait for ready
    task cmd(input [1:0] k, input [4:0] dev, input [4:0] idx, input [15:0] d, input ie);
        wr(`MDM_CMD_OFFSET, {2'b00, ie, 1'b0, k, dev, idx, d});
        repeat (2) @(posedge sys_clk);
        #1;
        n = 0;
        while (reg_rdata[28] !== 1'b1 && n < 3000) begin
            @(posedge sys_clk);
            #1;
            n = n + 1;
        end
        `CHK("latency", 1'b1, n < 2560)
    endtask
    task t_write;
        cmd(`MDM_KIND_WRITE, 5'h02, 5'h00, 16'hC3A5, 1'b1);
        `CHK("wr_frame", {`MDM_PREAMBLE, 2'b01, 5'h02, 5'h00, 2'b10, 16'hC3A5}, got[61:0])
        `CHK("wr_irq", 1, irqs)
    endtask
    task t_read;
        rd_data = 16'h5AC3;
        cmd(`MDM_KIND_READ, 5'h01, 5'h1F, 16'h0000, 1'b1);
        `CHK("rd_frame", {`MDM_PREAMBLE, 4'h6, 5'h01, 5'h1F, 2'b10, 16'h5AC3}, got)
        `CHK("rd_data", {1'b0, 16'h5AC3}, {reg_rdata[30], reg_rdata[15:0]})
        `CHK("rd_irq", 2, irqs)
    endtask
    task t_abort;
        bad_ta = 1'b1;
        cmd(`MDM_KIND_READ, 5'h02, 5'h03, 16'h0000, 1'b0);
        bad_ta = 1'b0;
        `CHK("abort", {3'b101, `MDM_DATA_ERR}, {reg_rdata[30:28], reg_rdata[15:0]})
        `CHK("ab_irq", 2, irqs)
    endtask
    task t_reserved;
        integer i, m;
        for (i = 0; i < 4; i = i + 3) begin
            m = edges;
            cmd(i[1:0], 5'h01, 5'h04, 16'h1234, 1'b0);
            `CHK("rsv_link", m, edges)
            `CHK("rsv_ready", 2'b01, {reg_rdata[30], reg_rdata[28]})
        end
    endtask
    task t_busy;
        wr(`MDM_CMD_OFFSET, {4'h0, `MDM_KIND_WRITE, 5'h01, 5'h07, 16'h0F0F});
        repeat (100) @(posedge sys_clk);
        cmd(`MDM_KIND_WRITE, 5'h02, 5'h09, 16'hFFFF, 1'b0);
        `CHK("busy_frame", {`MDM_PREAMBLE, 2'b01, 5'h01, 5'h07, 2'b10, 16'h0F0F}, got[61:0])
    endtask
    task t_unmapped;
        wr(20'h0_0024, 32'hFFFF_FFFF);
        @(posedge sys_clk);
        #1;
        reg_addr = 20'h0_0024;
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK("unmapped", 32'h0000_0000, reg_rdata)
        reg_addr = `MDM_CMD_OFFSET;
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK("kept", 32'h1427_0F0F, reg_rdata)
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK("reset", 32'h1000_0000, reg_rdata)
        t_write;
        t_read;
        t_abort;
        t_reserved;
        t_busy;
        t_unmapped;
        end_of_test;
    end
endmodule
